/* hdl/phy_frame_header_encoder.v */
// frame header encoder: start pattern, signalling codeword, coded block pass-through
//
// How it works
// - start pattern, then codeword, then coded block
// - fixed 26-symbol start pattern every frame
// - 64-bit codeword, 7 info bits, distance 32
// - pattern plus codeword fill one 90-symbol slot
// - header always pi/2-BPSK regardless of block modulation
// - constellation turns a quarter each header symbol
// - info bits carry modulation, rate, pilots, length
// - broadcast blocks always 64800 bits long
// - adaptive mode also allows 16200-bit blocks
// - broadcast keeps signalling fixed frame to frame
// - first six bits through [32,6,16] reed-muller code
// - generator built by recursive |u|u+v| construction
// - lower branch XORed with seventh info bit
// - branches interleaved bitwise, upper bit first
// - codeword scrambled by fixed extended m-sequence
// - pilot setting switchable and signalled in header
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "frame_header_map.vh"
module phy_frame_header_encoder
#(
  parameter [63:0] PLS_SCRAMBLE = `PLS_SCRAMBLE,
  parameter [25:0] SOF_PATTERN = `SOF_PATTERN
)
(
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp_out,
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // axi4-lite read
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // coded block symbols in
  input wire data_valid_in,
  output wire data_ready_out,
  input wire [7:0] data_i_in,
  input wire [7:0] data_q_in,
  // symbol stream out
  output wire sym_valid_out,
  input wire sym_ready_in,
  output wire [7:0] sym_i_out,
  output wire [7:0] sym_q_out,
  output wire sym_sof_out,
  output wire sym_header_out
);

  // ****************************************
  // states
  // ****************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_HDR = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;

  // ****************************************
  // declarations
  // ****************************************
  reg awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  reg aw_held_q, w_held_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [1:0] bresp_q, rresp_q;
  reg [31:0] rdata_q;
  reg [1:0] ctrl_q;
  reg [10:0] signal_q;
  reg [2:0] state_q, state_d;
  reg [6:0] hdr_cnt_q, hdr_cnt_d;
  reg [1:0] rot_q, rot_d;
  reg [16:0] bits_cnt_q, bits_cnt_d;
  reg [6:0] info_q, info_d;
  reg [15:0] frames_q, frames_d;
  reg out_valid_q, out_valid_d;
  reg [7:0] out_i_q, out_i_d, out_q_q, out_q_d;
  reg out_sof_q, out_sof_d, out_hdr_q, out_hdr_d;
  reg data_ready_q, data_ready_d;
  reg [16:0] bits_sum;
  reg [7:0] amp;
  wire [63:0] code;
  wire [6:0] pls_full;
  wire hdr_bit;
  wire [6:0] info_next;
  wire [2:0] bps;
  wire [16:0] frame_len;
  wire take, free;
  wire aw_fire, w_fire, ar_fire, do_write;
  wire aw_held_n, w_held_n, rvalid_n;
  wire enable, adaptive_coding_modulation;

  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign aw_fire = s_axi_awvalid_in & awready_q;
  assign w_fire = s_axi_wvalid_in & wready_q;
  assign ar_fire = s_axi_arvalid_in & arready_q;
  // the write waits until a pending response is gone
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;
  assign aw_held_n = (aw_held_q | aw_fire) & ~do_write;
  assign w_held_n = (w_held_q | w_fire) & ~do_write;
  assign rvalid_n = (rvalid_q & ~s_axi_rready_in) | ar_fire;

  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= `CTRL_RESET;
      signal_q <= `SIGNAL_RESET;
    end
    else
    begin
      awready_q <= ~aw_held_n;
      wready_q <= ~w_held_n;
      arready_q <= ~rvalid_n;
      aw_held_q <= aw_held_n;
      w_held_q <= w_held_n;
      if (aw_fire)
        aw_addr_q <= s_axi_awaddr_in;
      if (w_fire)
      begin
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= `RESP_OKAY;
        case (aw_addr_q)
          `OFS_CTRL:
          begin
            if (w_strb_q[0])
              ctrl_q <= w_data_q[1:0];
          end
          `OFS_SIGNAL:
          begin
            // pilots, short length, modulation and rate are all software picks
            if (w_strb_q[0])
              signal_q[6:0] <= w_data_q[6:0];
            if (w_strb_q[1])
              signal_q[10:8] <= w_data_q[10:8];
          end
          `OFS_STATUS, `OFS_CODE_HI, `OFS_CODE_LO:
            bresp_q <= `RESP_OKAY;
          default:
            bresp_q <= `RESP_SLVERR;
        endcase
      end
      else if (s_axi_bready_in)
        bvalid_q <= 1'b0;
      rvalid_q <= rvalid_n;
      if (ar_fire)
      begin
        rresp_q <= `RESP_OKAY;
        case (s_axi_araddr_in)
          `OFS_CTRL:
            rdata_q <= {30'h0000_0000, ctrl_q};
          `OFS_SIGNAL:
            rdata_q <= {21'h00_0000, signal_q};
          `OFS_STATUS:
            rdata_q <= {frames_q, 14'h0000, state_q[1], ~state_q[0]};
          `OFS_CODE_HI:
            rdata_q <= code[63:32];
          `OFS_CODE_LO:
            rdata_q <= code[31:0];
          default:
          begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ****************************************
  // signalling codeword
  // ****************************************
  assign enable = ctrl_q[`CTRL_ENABLE_BIT];
  assign adaptive_coding_modulation = ctrl_q[`CTRL_ACM_BIT];
  // short blocks only exist in adaptive mode
  assign info_next = {signal_q[`SIG_MODCOD_MSB:`SIG_MODCOD_LSB],
                      adaptive_coding_modulation & signal_q[`SIG_SHORT_BIT],
                      signal_q[`SIG_PILOT_BIT]};
  assign frame_len = info_q[1] ? `LEN_SHORT : `LEN_NORMAL;
  // a zero width would never end the block, so it counts as one bit
  assign bps = (signal_q[`SIG_BPS_MSB:`SIG_BPS_LSB] == 3'h0) ? 3'h1
             : signal_q[`SIG_BPS_MSB:`SIG_BPS_LSB];

  pls_codeword_builder #(
    .SCRAMBLE(PLS_SCRAMBLE)
  ) u_pls (
    .info_in(info_q),
    .code_out(code)
  );

  assign pls_full = hdr_cnt_q - `SOF_SYMBOLS;
  assign hdr_bit = (hdr_cnt_q < `SOF_SYMBOLS) ? SOF_PATTERN[5'd25 - hdr_cnt_q[4:0]]
                 : code[6'd63 - pls_full[5:0]];

  // ****************************************
  // framing state machine
  // ****************************************
  assign take = out_valid_q & sym_ready_in;
  assign free = ~out_valid_q | take;

  always @*
  begin
    state_d = state_q;
    hdr_cnt_d = hdr_cnt_q;
    rot_d = rot_q;
    bits_cnt_d = bits_cnt_q;
    info_d = info_q;
    frames_d = frames_q;
    out_valid_d = out_valid_q & ~take;
    out_i_d = out_i_q;
    out_q_d = out_q_q;
    out_sof_d = out_sof_q;
    out_hdr_d = out_hdr_q;
    bits_sum = bits_cnt_q + {14'h0000, bps};
    amp = hdr_bit ? `SYM_NEG : `SYM_POS;
    case (state_q)
      ST_IDLE:
      begin
        if (enable)
        begin
          state_d = ST_HDR;
          hdr_cnt_d = 7'h00;
          rot_d = 2'h0;
          info_d = info_next;
        end
      end
      ST_HDR:
      begin
        if (free)
        begin
          out_valid_d = 1'b1;
          out_sof_d = (hdr_cnt_q == 7'h00);
          out_hdr_d = 1'b1;
          // pi/2-BPSK whatever the block uses, one quarter turn per symbol
          case (rot_q)
            2'h0:
            begin
              out_i_d = amp;
              out_q_d = 8'h00;
            end
            2'h1:
            begin
              out_i_d = 8'h00;
              out_q_d = amp;
            end
            2'h2:
            begin
              out_i_d = 8'h00 - amp;
              out_q_d = 8'h00;
            end
            default:
            begin
              out_i_d = 8'h00;
              out_q_d = 8'h00 - amp;
            end
          endcase
          rot_d = rot_q + 2'h1;
          if (hdr_cnt_q == `SLOT_LAST)
          begin
            state_d = ST_DATA;
            bits_cnt_d = 17'h0_0000;
          end
          else
            hdr_cnt_d = hdr_cnt_q + 7'h01;
        end
      end
      ST_DATA:
      begin
        if (data_valid_in & data_ready_q)
        begin
          out_valid_d = 1'b1;
          out_i_d = data_i_in;
          out_q_d = data_q_in;
          out_sof_d = 1'b0;
          out_hdr_d = 1'b0;
          if (bits_sum >= frame_len)
          begin
            frames_d = frames_q + 16'h0001;
            hdr_cnt_d = 7'h00;
            rot_d = 2'h0;
            state_d = enable ? ST_HDR : ST_IDLE;
            // broadcast keeps the first frame's signalling until restarted
            if (adaptive_coding_modulation)
              info_d = info_next;
          end
          else
            bits_cnt_d = bits_sum;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
    // one beat in flight keeps ready a flop, at half the block rate
    data_ready_d = (state_d == ST_DATA) & ~out_valid_d;
  end

  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_q <= ST_IDLE;
      hdr_cnt_q <= 7'h00;
      rot_q <= 2'h0;
      bits_cnt_q <= 17'h0_0000;
      info_q <= 7'h00;
      frames_q <= 16'h0000;
      out_valid_q <= 1'b0;
      out_i_q <= 8'h00;
      out_q_q <= 8'h00;
      out_sof_q <= 1'b0;
      out_hdr_q <= 1'b0;
      data_ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      hdr_cnt_q <= hdr_cnt_d;
      rot_q <= rot_d;
      bits_cnt_q <= bits_cnt_d;
      info_q <= info_d;
      frames_q <= frames_d;
      out_valid_q <= out_valid_d;
      out_i_q <= out_i_d;
      out_q_q <= out_q_d;
      out_sof_q <= out_sof_d;
      out_hdr_q <= out_hdr_d;
      data_ready_q <= data_ready_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign data_ready_out = data_ready_q;
  assign sym_valid_out = out_valid_q;
  assign sym_i_out = out_i_q;
  assign sym_q_out = out_q_q;
  assign sym_sof_out = out_sof_q;
  assign sym_header_out = out_hdr_q;

endmodule // phy_frame_header_encoder

/* hdl/frame_header_map.vh */
// register offsets, field positions, reset values and frame constants
`ifndef FRAME_HEADER_MAP_VH
`define FRAME_HEADER_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_SIGNAL 8'h04
`define OFS_STATUS 8'h08
`define OFS_CODE_HI 8'h0C
`define OFS_CODE_LO 8'h10

// ****************************************
// field positions
// ****************************************
`define CTRL_ENABLE_BIT 0
`define CTRL_ACM_BIT 1
`define SIG_PILOT_BIT 0
`define SIG_SHORT_BIT 1
`define SIG_MODCOD_LSB 2
`define SIG_MODCOD_MSB 6
`define SIG_BPS_LSB 8
`define SIG_BPS_MSB 10
`define STAT_BUSY_BIT 0
`define STAT_HDR_BIT 1
`define STAT_FRAMES_LSB 16

// ****************************************
// reset values
// ****************************************
`define CTRL_RESET 2'h0
`define SIGNAL_RESET 11'h200

// ****************************************
// frame constants
// ****************************************
`define SOF_SYMBOLS 7'h1A
`define PLS_BITS 7'h40
`define SLOT_LAST 7'h59
`define SOF_PATTERN 26'h2A5_5A5A
`define PLS_SCRAMBLE 64'h5A5A_3C3C_0FF0_A5C3
`define LEN_NORMAL 17'h0_FD20
`define LEN_SHORT 17'h0_3F48
`define SYM_POS 8'h7F
`define SYM_NEG 8'h81
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* hdl/pls_codeword_builder.v */
// signalling codeword builder: reed-muller code, branch interleave, scramble
`timescale 1ns/100ps
module pls_codeword_builder
#(
  parameter [63:0] SCRAMBLE = 64'h0000_0000_0000_0000
)
(
  // seven info bits, [6:1] to the reed-muller code, [0] the seventh bit
  input wire [6:0] info_in,
  // scrambled codeword, first bit sent in bit 63
  output wire [63:0] code_out
);

  wire [63:0] raw;

  genvar j;
  generate
    for (j = 0; j < 32; j = j + 1)
    begin : g_pair
      localparam integer IDX = j;
      // |u|u+v| recursion: each row halves its run length, last row all ones
      wire y = (info_in[6] & IDX[4]) ^ (info_in[5] & IDX[3]) ^ (info_in[4] & IDX[2])
             ^ (info_in[3] & IDX[1]) ^ (info_in[2] & IDX[0]) ^ info_in[1];
      assign raw[63 - 2 * j] = y;
      assign raw[62 - 2 * j] = y ^ info_in[0];
    end
  endgenerate

  assign code_out = raw ^ SCRAMBLE;

endmodule // pls_codeword_builder

/* dv/frame_header_asserts.sv */
// port checks for the frame header encoder
`timescale 1ns/100ps
module frame_header_asserts
#(
  parameter [25:0] SOF_PATTERN = 26'h0
)
(
  // clock and reset
  input logic clk_in,
  input logic reset_in,
  // register bus
  input logic s_axi_awvalid_in,
  input logic s_axi_awready_out,
  input logic s_axi_wvalid_in,
  input logic s_axi_wready_out,
  input logic s_axi_bvalid_out,
  input logic s_axi_arvalid_in,
  input logic s_axi_arready_out,
  input logic s_axi_rvalid_out,
  // streams
  input logic data_valid_in,
  input logic data_ready_out,
  input logic [7:0] data_i_in,
  input logic [7:0] data_q_in,
  input logic sym_valid_out,
  input logic sym_ready_in,
  input logic [7:0] sym_i_out,
  input logic [7:0] sym_q_out,
  input logic sym_sof_out,
  input logic sym_header_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // ****
  // header count and axis of last symbol
  // ****
  wire hs = sym_valid_out && sym_ready_in;
  logic [6:0] hcnt_q;
  logic qax_q;
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      hcnt_q <= 7'h00;
      qax_q <= 1'b0;
    end
    else if (hs)
    begin
      hcnt_q <= sym_sof_out ? 7'h01 : hcnt_q + {6'h00, sym_header_out};
      qax_q <= (sym_i_out == 8'h00);
    end
  end
  a_sym_stand:
  assert property (sym_valid_out && !sym_ready_in |=> sym_valid_out
    && $stable({sym_i_out, sym_q_out, sym_sof_out, sym_header_out}))
  else $error("symbol changed before taken");
  a_pass_through:
  assert property (data_valid_in && data_ready_out |=> sym_valid_out && !sym_header_out
    && sym_i_out == $past(data_i_in) && sym_q_out == $past(data_q_in))
  else $error("coded symbol not passed on");
  a_first_sym:
  assert property (hs && sym_sof_out |-> sym_header_out && sym_q_out == 8'h00
    && sym_i_out == (SOF_PATTERN[25] ? 8'h81 : 8'h7F))
  else $error("bad first header symbol");
  a_slot_length:
  assert property (hs && !sym_header_out |-> hcnt_q == 7'h5A)
  else $error("header not one slot long");
  a_bpsk_point:
  assert property (hs && sym_header_out |-> (sym_i_out == 8'h00 || sym_q_out == 8'h00)
    && ((sym_i_out | sym_q_out) == 8'h7F || (sym_i_out | sym_q_out) == 8'h81))
  else $error("header symbol off constellation");
  a_quarter_turn:
  assert property (hs && sym_header_out && !sym_sof_out |-> (sym_i_out == 8'h00) != qax_q)
  else $error("header rotation did not advance");
  a_write_answer:
  assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
  else $error("write response late");
  a_read_answer:
  assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
  else $error("read response late");
endmodule // frame_header_asserts

bind phy_frame_header_encoder frame_header_asserts #(.SOF_PATTERN(SOF_PATTERN)) i_chk (.*);

/* dv/frame_sync_sink.sv */
// receiver model: symbol sink with fast, slow and hold pacing
`timescale 1ns/100ps
module frame_sync_sink
(
  // clock, reset, pace 0 fast, 1 alternate, 2 hold
  input logic clk_in,
  input logic reset_in,
  input logic [1:0] pace_in,
  // symbol stream
  input logic sym_valid_in,
  input logic sym_sof_in,
  output logic sym_ready_out,
  output logic [15:0] frames_out
);
  logic rdy_q;
  // hold acts at once so no beat slips past a paused bench
  assign sym_ready_out = rdy_q && (pace_in != 2'h2);
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rdy_q <= 1'b0;
      frames_out <= 16'h0000;
    end
    else
    begin
      rdy_q <= (pace_in != 2'h1) || !rdy_q;
      if (sym_valid_in && sym_ready_out && sym_sof_in)
        frames_out <= frames_out + 16'h0001;
    end
  end
endmodule // frame_sync_sink

/* dv/phy_frame_header_encoder_test.sv */
// self-checking bench for the frame header encoder
`timescale 1ns/100ps
`include "frame_header_map.vh"
module phy_frame_header_encoder_test;
  localparam [25:0] SOFP = `SOF_PATTERN;
  localparam [63:0] SCR = `PLS_SCRAMBLE;
  logic clk_in, reset_in, data_valid_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, data_i_in, data_q_in, dout;
  logic [31:0] s_axi_wdata_in;
  logic [3:0] s_axi_wstrb_in;
  logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  logic [1:0] pace;
  logic [63:0] cw;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  wire s_axi_rvalid_out, data_ready_out, sym_valid_out, sym_sof_out, sym_header_out;
  wire sym_ready_in;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire [7:0] sym_i_out, sym_q_out;
  wire [15:0] frames;
  integer n_errors = 0, compares = 0, t, k;
  phy_frame_header_encoder i_dut (.*);
  frame_sync_sink i_sink (.clk_in(clk_in), .reset_in(reset_in), .pace_in(pace),
    .sym_valid_in(sym_valid_out), .sym_sof_in(sym_sof_out),
    .sym_ready_out(sym_ready_in), .frames_out(frames));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
    if (reset_in)
      data_i_in <= 8'h00;
    else if (data_valid_in && data_ready_out === 1'b1)
      data_i_in <= data_i_in + 8'h01;
  // ****
  // shared tasks
  // ****
  // wide enough for a read response code in front of its data word
  task chk(input logic [33:0] got, input logic [33:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    begin
      @(posedge clk_in);
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} <= {a, a, d};
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= {w, w, w};
      {s_axi_arvalid_in, s_axi_rready_in} <= {!w, !w};
      t = 0;
      while (t < 99 && (t == 0 || s_axi_bready_in || s_axi_rready_in))
      begin
        @(posedge clk_in);
        t = t + 1;
        if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
        if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
        if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
        if (s_axi_bvalid_out === 1'b1 && s_axi_bready_in)
        begin
          s_axi_bready_in <= 1'b0;
          chk(s_axi_bresp_out, er);
        end
        if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in)
        begin
          s_axi_rready_in <= 1'b0;
          chk({s_axi_rresp_out, s_axi_rdata_out}, {er, d});
        end
      end
      if (t >= 99) chk(0, 1);
    end
  endtask
  function logic [63:0] code(input logic [6:0] f);
    integer j;
    logic y;
    begin
      for (j = 0; j < 32; j = j + 1)
      begin
        y = ^(f[6:2] & j[4:0]) ^ f[1];
        code[63 - 2 * j] = y;
        code[62 - 2 * j] = y ^ f[0];
      end
      code = code ^ SCR;
    end
  endfunction
  task beat;
    begin
      t = 0;
      @(posedge clk_in);
      while (!(sym_valid_out === 1'b1 && sym_ready_in === 1'b1) && t < 999)
      begin
        @(posedge clk_in);
        t = t + 1;
      end
      if (t >= 999) chk(0, 1);
    end
  endtask
  task hdr(input logic [63:0] c, input logic p);
    logic [7:0] a, e, ei, eq;
    logic [63:0] obs;
    begin
      for (k = 0; k < 90; k = k + 1)
      begin
        beat();
        a = (k < 26 ? SOFP[25 - k] : c[89 - k]) ? 8'h81 : 8'h7F;
        e = (k % 4 > 1) ? 8'h00 - a : a;
        ei = (k % 2) ? 8'h00 : e;
        eq = (k % 2) ? e : 8'h00;
        chk({sym_i_out, sym_q_out, sym_sof_out, sym_header_out}, {ei, eq, k == 0, 1'b1});
        // receiver view: take the bit back off the point, undoing the half turn
        if (k >= 26)
          obs[89 - k] = ((sym_i_out | sym_q_out) == 8'h81) ^ (k % 4 > 1);
      end
      // once descrambled, every adjacent pair differs by the seventh bit
      for (k = 0; k < 32; k = k + 1)
        chk(^(obs[63 - 2 * k -: 2] ^ SCR[63 - 2 * k -: 2]), p);
    end
  endtask
  task blk(input integer nb);
    begin
      for (k = 0; k < nb; k = k + 1)
      begin
        beat();
        chk({sym_i_out, sym_q_out, sym_header_out}, {dout, 8'hC3, 1'b0});
        dout = dout + 8'h01;
      end
    end
  endtask
  task idle(input logic [31:0] st);
    begin
      repeat (20) @(posedge clk_in);
      chk(sym_valid_out, 1'b0);
      axi(0, `OFS_STATUS, st, `RESP_OKAY);
    end
  endtask
  // ****
  // scenarios
  // ****
  task regs;
    begin
      axi(0, `OFS_CTRL, 32'h0, `RESP_OKAY);
      axi(0, `OFS_SIGNAL, 32'h0000_0200, `RESP_OKAY);
      axi(1, 8'h20, 32'h1, `RESP_SLVERR);
      axi(0, 8'h20, 32'h0, `RESP_SLVERR);
      axi(1, `OFS_STATUS, 32'hFFFF_FFFF, `RESP_OKAY);
      axi(0, `OFS_STATUS, 32'h0, `RESP_OKAY);
      $display("register test done");
    end
  endtask
  task bcast;
    begin
      cw = code(7'h55);
      // short flag set: broadcast must ignore it and keep the long block
      axi(1, `OFS_SIGNAL, 32'h0000_0757, `RESP_OKAY);
      axi(1, `OFS_CTRL, 32'h1, `RESP_OKAY);
      hdr(cw, 1'b1);
      pace <= 2'h2;
      axi(0, `OFS_CODE_HI, cw[63:32], `RESP_OKAY);
      axi(0, `OFS_CODE_LO, cw[31:0], `RESP_OKAY);
      axi(1, `OFS_SIGNAL, 32'h0000_0728, `RESP_OKAY);
      pace <= 2'h0;
      blk(9258);
      hdr(cw, 1'b1);
      pace <= 2'h2;
      axi(1, `OFS_CTRL, 32'h0, `RESP_OKAY);
      pace <= 2'h1;
      blk(9258);
      idle(32'h0002_0000);
      $display("broadcast test done");
    end
  endtask
  task adaptive;
    begin
      cw = code(7'h2A);
      axi(1, `OFS_SIGNAL, 32'h0000_072A, `RESP_OKAY);
      axi(1, `OFS_CTRL, 32'h3, `RESP_OKAY);
      hdr(cw, 1'b0);
      pace <= 2'h2;
      axi(1, `OFS_CTRL, 32'h2, `RESP_OKAY);
      pace <= 2'h0;
      blk(2315);
      idle(32'h0003_0000);
      $display("adaptive test done");
    end
  endtask
  task final_report;
    begin
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    // the scenarios need about 45 000 cycles; 70 000 leaves margin
    #700_000;
    n_errors = n_errors + 1;
    final_report();
  end
  initial
  begin
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, dout} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in, pace} = '0;
    s_axi_wstrb_in = 4'hF;
    data_q_in = 8'hC3;
    data_valid_in = 1'b1;
    reset_in = 1'b1;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    regs();
    bcast();
    adaptive();
    chk(frames, 32'h3);
    final_report();
  end
endmodule // phy_frame_header_encoder_test
